/* core/clkout_pkg.sv */
// constants for the phase clock output and shutdown test block
// assumes a single 250 MHz system clock standing in for the input clock
package clkout_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned DIV_RATIO = 2;
  // ****************************************
  // reset and park values
  // ****************************************
  localparam logic RST_PHASE = 1'b0;
  localparam logic PARK_LEVEL = 1'b1;
  localparam logic [2:0] RST_VECTOR = 3'h0;
  // ****************************************
  // mode encoding
  // ****************************************
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_HIZ = 2'b01,
    MODE_PARK = 2'b10
  } mode_t;
endpackage

/* core/phase_div.sv */
// divide-by-two phase generator feeding both phase clock outputs
// assumes synchronous reset and a free running clock
module phase_div (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_run,
  output logic o_phase
);
  import clkout_pkg::*;
  // one toggle shared by both outputs keeps their relative phase fixed
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_run) begin
      o_phase <= RST_PHASE;
    end else begin
      o_phase <= ~o_phase;
    end
  end
endmodule

/* core/clock_out_and_shutdown_test.sv */
// phase clock outputs with shutdown / leakage test mode
// assumes i_clk_sys models the input clock; pins are synchronous inputs;
// the pad ring resolves output enables and the board pulls
// ****************************************
// Notes on behaviour
// ****************************************
module clock_out_and_shutdown_test (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_reset_n,
  input wire logic i_shutdown_hiz_n,
  input wire logic i_first_phase_clock_in,
  input wire logic i_second_phase_clock_in,
  output logic o_first_phase_clock_out,
  output logic o_first_phase_clock_oe,
  output logic o_second_phase_clock_out,
  output logic o_second_phase_clock_oe,
  output logic o_pins_oe,
  output logic o_osc_enable,
  output logic o_core_in_reset,
  output logic [2:0] o_fetch_vector
);
  import clkout_pkg::*;

  mode_t mode_q;
  logic hiz_n_q;
  logic phase;
  logic pulled_low;
  logic run;

  // only a divide by two is built; other ratios would need a counter
  if (DIV_RATIO != 2) begin : g_ratio_check
    $error("phase divider supports a ratio of two only");
  end

  // ****************************************
  // shutdown sampling and mode control
  // ****************************************
  // one register stage: the pin is already synchronous to the clock
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hiz_n_q <= 1'b1;
    end else begin
      hiz_n_q <= i_shutdown_hiz_n;
    end
  end

  // either pin read low by the board is enough to wake
  assign pulled_low = !i_first_phase_clock_in || !i_second_phase_clock_in;
  assign run = (mode_q == MODE_RUN);

  // reset is deliberately absent from the exit path: in silicon the
  // clock is stopped, so only a pin pulled low can restart it
  always_ff @(posedge i_clk_sys) begin
    case (mode_q)
      MODE_RUN: begin
        if (!hiz_n_q) begin
          mode_q <= MODE_HIZ;
        end
      end
      MODE_HIZ: begin
        mode_q <= MODE_PARK;
      end
      MODE_PARK: begin
        if (pulled_low) begin
          mode_q <= MODE_RUN;
        end
      end
      default: begin
        mode_q <= MODE_RUN;
      end
    endcase
    if (i_sys_rst && mode_q != MODE_PARK) begin
      mode_q <= MODE_RUN;
    end
  end

  phase_div phase_div_inst (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_run(run),
    .o_phase(phase)
  );

  // ****************************************
  // output pins
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst && mode_q != MODE_PARK) begin
      o_first_phase_clock_out <= RST_PHASE;
      o_second_phase_clock_out <= ~RST_PHASE;
      o_first_phase_clock_oe <= 1'b1;
      o_second_phase_clock_oe <= 1'b1;
      o_pins_oe <= 1'b1;
    end else if (run && hiz_n_q) begin
      o_first_phase_clock_out <= ~phase;
      o_second_phase_clock_out <= phase;
      o_first_phase_clock_oe <= 1'b1;
      o_second_phase_clock_oe <= 1'b1;
      o_pins_oe <= 1'b1;
    end else if (mode_q == MODE_PARK) begin
      o_first_phase_clock_out <= PARK_LEVEL;
      o_second_phase_clock_out <= PARK_LEVEL;
      o_first_phase_clock_oe <= 1'b1;
      o_second_phase_clock_oe <= 1'b1;
      o_pins_oe <= 1'b0;
    end else begin
      // entry step: pins released before the clocks are parked
      o_first_phase_clock_oe <= 1'b0;
      o_second_phase_clock_oe <= 1'b0;
      o_pins_oe <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    // a reset while parked must not restart the oscillator
    if (i_sys_rst && mode_q != MODE_PARK) begin
      o_osc_enable <= 1'b1;
    end else begin
      o_osc_enable <= run && hiz_n_q;
    end
  end

  // ****************************************
  // core reset and restart vector
  // ****************************************
  // state is lost in test mode, so the core is held in reset there
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_core_in_reset <= 1'b1;
      o_fetch_vector <= RST_VECTOR;
    end else begin
      o_core_in_reset <= !i_reset_n || !run;
      o_fetch_vector <= RST_VECTOR;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_enter;
    run && !hiz_n_q;
  endsequence
  sequence s_hiz;
    mode_q == MODE_HIZ;
  endsequence
  sequence s_parked;
    mode_q == MODE_PARK;
  endsequence
  // wake: parked, then running with the shutdown input high again
  sequence s_resume;
    s_parked ##1 (run && hiz_n_q);
  endsequence

  a_half_rate: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    run && hiz_n_q && $past(run && hiz_n_q) |=>
    o_first_phase_clock_out != $past(o_first_phase_clock_out))
    else $error("first phase clock not at half rate");
  a_second_rate: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    run && hiz_n_q && $past(run && hiz_n_q) |=>
    o_second_phase_clock_out != $past(o_second_phase_clock_out))
    else $error("second phase clock not at half rate");
  a_phase_pair: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    run && $past(run) && $past(hiz_n_q) |->
    o_second_phase_clock_out != o_first_phase_clock_out)
    else $error("phase clocks lost their pairing");
  a_enter_park: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    s_enter |=> !o_pins_oe ##1 s_parked ##1
    (o_first_phase_clock_out && o_second_phase_clock_out))
    else $error("shutdown entry sequence wrong");
  a_hiz_off: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    s_hiz |-> !o_first_phase_clock_oe && !o_second_phase_clock_oe &&
    !o_pins_oe)
    else $error("pins still driven during shutdown entry");
  a_osc_off: assert property (
    @(posedge i_clk_sys)
    s_parked |=> !o_osc_enable)
    else $error("oscillator running in test mode");
  a_reset_park: assert property (
    @(posedge i_clk_sys)
    (s_parked and (i_sys_rst && !pulled_low)) |=> mode_q == MODE_PARK &&
    !o_pins_oe && o_first_phase_clock_out && o_second_phase_clock_out)
    else $error("reset disturbed test mode");
  a_wake_pull: assert property (
    @(posedge i_clk_sys)
    (s_parked and !pulled_low) |=> s_parked)
    else $error("test mode left without a pulled clock");
  a_wake_exit: assert property (
    @(posedge i_clk_sys)
    (s_parked and pulled_low) |=> run)
    else $error("test mode not left after pull low");
  a_resume_run: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    s_resume |=> o_pins_oe && o_osc_enable && o_first_phase_clock_oe)
    else $error("pins not restored after wake");
  a_core_hold: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_reset_n |=> o_core_in_reset)
    else $error("core not held in reset");
  a_core_free: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_reset_n && run |=> !o_core_in_reset && o_fetch_vector == RST_VECTOR)
    else $error("core not released to the reset vector");
  a_state_lost: assert property (
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    s_parked |=> o_core_in_reset)
    else $error("core not reset in test mode");
  a_reset_known: assert property (
    @(posedge i_clk_sys)
    $fell(i_sys_rst) && $past(mode_q != MODE_PARK) |->
    o_core_in_reset && o_pins_oe && o_osc_enable &&
    o_first_phase_clock_out == RST_PHASE && o_second_phase_clock_out)
    else $error("outputs not in known state after reset");
endmodule

/* testbench/board_pulls.sv */
// board side of one phase clock pin: pull-up plus test probe
// assumes the probe overpowers the pin when it pulls low
module board_pulls (
  input wire logic i_drv,
  input wire logic i_oe,
  input wire logic i_pull_low,
  output logic o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pin floats up to the pull-up level
  assign o_pad = i_pull_low ? 1'b0 : (i_oe ? i_drv : 1'b1);
endmodule

/* testbench/clock_out_and_shutdown_test_test.sv */
// bench for the phase clock and shutdown block
// assumes board_pulls models both phase clock pins
module clock_out_and_shutdown_test_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, rst_n = 0, hiz_n = 1, pull = 0, pull2 = 0;
  logic f_in, s_in, f_o, f_oe, s_o, s_oe, p_oe, osc, cir;
  logic [2:0] vec;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  initial forever #2 clk = ~clk;
  clock_out_and_shutdown_test clock_out_and_shutdown_test_inst (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_reset_n(rst_n),
    .i_shutdown_hiz_n(hiz_n), .i_first_phase_clock_in(f_in),
    .i_second_phase_clock_in(s_in), .o_first_phase_clock_out(f_o),
    .o_first_phase_clock_oe(f_oe), .o_second_phase_clock_out(s_o),
    .o_second_phase_clock_oe(s_oe), .o_pins_oe(p_oe),
    .o_osc_enable(osc), .o_core_in_reset(cir), .o_fetch_vector(vec));
  board_pulls board_pulls_inst (.i_drv(f_o), .i_oe(f_oe),
    .i_pull_low(pull), .o_pad(f_in));
  board_pulls board_pulls_inst2 (.i_drv(s_o), .i_oe(s_oe),
    .i_pull_low(pull2), .o_pad(s_in));
  // ****************************************
  // checking
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_running();
    logic a;
    cycles(1);
    a = f_o;
    check({7'h0, $isunknown(a)}, 8'h00);
    check({3'h0, s_o, f_oe, s_oe, p_oe, osc}, {3'h0, ~a, 4'hf});
    cycles(1);
    check({7'h0, f_o}, {7'h0, ~a});
    check({7'h0, s_o}, {7'h0, a});
    $display("test running done");
  endtask
  task automatic t_core_reset();
    check({4'h0, cir, vec}, 8'h08);
    @(posedge clk) rst_n <= 1;
    cycles(3);
    check({4'h0, cir, vec}, 8'h00);
    $display("test core reset done");
  endtask
  task automatic t_park();
    @(posedge clk) hiz_n <= 0;
    cycles(3);
    check({7'h0, p_oe}, 8'h00);
    cycles(3);
    // parked: clocks driven high, other pins and oscillator off
    check({2'h0, f_o, f_oe, s_o, s_oe, p_oe, osc}, 8'h3c);
    check({7'h0, cir}, 8'h01);
    @(posedge clk) begin
      rst <= 1;
      rst_n <= 0;
      hiz_n <= 1;
    end
    cycles(4);
    check({2'h0, f_o, f_oe, s_o, s_oe, p_oe, osc}, 8'h3c);
    @(posedge clk) rst <= 0;
    cycles(4);
    check({5'h0, f_o, s_o, osc}, 8'h06);
    @(posedge clk) pull <= 1;
    @(posedge clk) pull <= 0;
    cycles(4);
    check({6'h0, osc, p_oe}, 8'h03);
    $display("test park done");
  endtask
  task automatic t_recover();
    @(posedge clk) rst <= 1;
    cycles(2);
    @(posedge clk) rst <= 0;
    @(posedge clk) rst_n <= 1;
    cycles(3);
    check({4'h0, cir, vec}, 8'h00);
    $display("test recover done");
  endtask
  // wake through the second phase clock pin alone
  task automatic t_wake_second();
    @(posedge clk) hiz_n <= 0;
    cycles(6);
    check({5'h0, f_o, s_o, osc}, 8'h06);
    @(posedge clk) begin
      hiz_n <= 1;
      pull2 <= 1;
    end
    @(posedge clk) pull2 <= 0;
    cycles(4);
    check({6'h0, osc, p_oe}, 8'h03);
    $display("test wake second done");
  endtask
  initial begin
    cycles(12);
    @(posedge clk) rst <= 0;
    cycles(2);
    t_running();
    t_core_reset();
    t_park();
    t_running();
    t_recover();
    t_running();
    t_wake_second();
    t_recover();
    t_running();
    print_verdict();
  end
endmodule
